// ### src/tscp_pkg.sv
// Purpose: Shared constants and types of the converter's serial command port.
// Assumes: System clock of 4 ns period.
// Notes: Pin order of the input synchroniser is fixed here.
package tscp_pkg;

  // ---------------------------------------------------------------
  // Serial link and registers
  // ---------------------------------------------------------------
  localparam int DATA_W_DEF = 24;
  localparam int CNT_W = 7;
  localparam int REG_NUM = 8;
  localparam logic [2:0] CFG_ADDR = 3'h0;
  localparam logic [4:0] OP_WRITE = 5'h10;
  localparam logic [4:0] OP_READ = 5'h16;
  localparam int FIRE_CNT_LSB = 0;
  localparam int FIRE_CNT_W = 4;

  // ---------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] cmd_init = 8'h70;
  localparam logic [7:0] cmd_power_reset = 8'h50;
  localparam logic [7:0] cmd_start_cycle = 8'h01;
  localparam logic [7:0] cmd_start_temp = 8'h02;
  localparam logic [7:0] cmd_calib_resonator = 8'h03;
  localparam logic [7:0] cmd_calib_converter = 8'h04;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 4;
  localparam int HIT_DELAY_NS = 200;
  localparam logic [7:0] HIT_DELAY_CYC = 8'((HIT_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam int FAST_MIN_MHZ = 2;
  localparam int FAST_MAX_MHZ = 8;
  localparam logic [7:0] FAST_MIN_CYC = 8'((1000 + FAST_MAX_MHZ * SYS_PERIOD_NS - 1) / (FAST_MAX_MHZ * SYS_PERIOD_NS));
  localparam logic [7:0] FAST_MAX_CYC = 8'(1000 / (FAST_MIN_MHZ * SYS_PERIOD_NS));
  localparam logic [15:0] FIRE_HALF_CYC = 16'h0010;
  localparam logic [15:0] LOAD_CYC = 16'h0040;
  localparam int MEAS_TIMEOUT_DEF = 65535;
  localparam int TEMP_TIMEOUT_DEF = 65535;

  // ---------------------------------------------------------------
  // Synchroniser bit positions and result tags
  // ---------------------------------------------------------------
  localparam int PIN_RESET = 0, PIN_START = 1, PIN_START_EN = 2, PIN_STOPA = 3, PIN_STOPA_EN = 4;
  localparam int PIN_STOPB = 5, PIN_STOPB_EN = 6, PIN_FIRE = 7, PIN_SENSE = 8, PIN_SLOW = 9;
  localparam int PIN_FAST = 10, PIN_CMD = 11, PIN_NUM = 12;
  localparam logic [2:0] TAG_MEAS = 3'h4;
  localparam logic [2:0] TAG_CAL = 3'h5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIRE = 3'b001,
    ST_MEAS = 3'b010,
    ST_LOAD = 3'b011,
    ST_DISCH = 3'b100,
    ST_CALWAIT = 3'b101,
    ST_CAL = 3'b110
  } tscp_state_t;

endpackage : tscp_pkg

// ### src/tscp_serial_port.sv
// Purpose: Serial command port and pin control of a two-channel converter.
// Assumes: Serial clock idles low; host keeps select high between frames.
// Notes: Register file lives on the serial clock; commands cross by toggle.
`timescale 1ns/1ns

// What this block does
// - Serial slave with clock phase one and polarity zero.
// - Opcode 10000aaa writes the following data word to register aaa.
// - Opcode 10110aaa shifts register aaa out to the host.
// - Serial input is sampled on each falling serial clock edge.
// - Serial output changes after each rising serial clock edge.
// - Serial output enable is high only while returning read data.
// - Hits are ignored until 200 ns after reset input rises.
// - Each stop input is taken only while its enable is high.
// - Start input is taken only while start enable is high.
// - Two fire pulse outputs drive the transducers.
// - Fire input retriggers the fire burst during a measurement.
// - Temperature unit drives four ports and load, watches the sense input.
// - The slow reference input serves as the slow clock.
// - The slow clock is repeated on its own output.
// - The fast reference clock is checked against the 2 to 8 MHz range.
module tscp_serial_port #(
  parameter int DATA_W = tscp_pkg::DATA_W_DEF,
  parameter int MEAS_TIMEOUT = tscp_pkg::MEAS_TIMEOUT_DEF,
  parameter int TEMP_TIMEOUT = tscp_pkg::TEMP_TIMEOUT_DEF
) (
  input logic sys_clk,
  input logic rst,
  input logic spiClk,
  input logic slave_select_n,
  input logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input logic reset_in_n,
  input logic startIn,
  input logic startEnable,
  input logic stop_a_in,
  input logic stop_a_enable,
  input logic stop_b_in,
  input logic stop_b_enable,
  input logic fireIn,
  input logic discharge_sense_in,
  input logic slow_clock_in,
  input logic fast_reference_clock,
  output logic pulse_out_a,
  output logic pulse_out_b,
  output logic sensor_port_a,
  output logic sensor_port_b,
  output logic sensor_port_c,
  output logic sensor_port_d,
  output logic charge_load_out,
  output logic slow_clock_out,
  output logic irq_out_n,
  output logic hitStart,
  output logic hitStopA,
  output logic hitStopB,
  output logic [15:0] resultData,
  output logic [2:0] resultTag,
  output logic resultValid,
  output logic convCalStart,
  output logic fastClockOk
);
  import tscp_pkg::*;

  // ---------------------------------------------------------------
  // Serial clock domain, falling edge
  // ---------------------------------------------------------------
  logic frameRst;
  logic [CNT_W-1:0] bitCnt, next_bitCnt;
  logic [DATA_W-1:0] shiftIn, next_shiftIn;
  logic [7:0] opcode, next_opcode;
  logic [DATA_W-1:0] regs [REG_NUM];
  logic [DATA_W-1:0] next_regs [REG_NUM];
  logic cmdToggle, next_cmdToggle;
  logic [7:0] cmdCode, next_cmdCode;
  logic [DATA_W-1:0] cmdCfg, next_cmdCfg;
  logic [DATA_W-1:0] shiftNew;
  logic opDone;
  logic wordDone;
  logic isCmd;

  assign frameRst = rst | slave_select_n;

  always_comb begin
    shiftNew = {shiftIn[DATA_W-2:0], serialIn};
    opDone = (bitCnt == CNT_W'(7));
    wordDone = (bitCnt == CNT_W'(7 + DATA_W)) && (opcode[7:3] == OP_WRITE);
    isCmd = (shiftNew[7:3] != OP_WRITE) && (shiftNew[7:3] != OP_READ);
    next_bitCnt = (bitCnt == CNT_W'(8 + DATA_W)) ? bitCnt : bitCnt + 1'b1;
    next_shiftIn = shiftNew;
    next_opcode = opDone ? shiftNew[7:0] : opcode;
    next_regs = regs;
    next_cmdToggle = cmdToggle;
    next_cmdCode = cmdCode;
    next_cmdCfg = cmdCfg;
    if (wordDone) begin
      next_regs[opcode[2:0]] = shiftNew;
    end
    if (opDone && isCmd) begin
      next_cmdToggle = ~cmdToggle;
      next_cmdCode = shiftNew[7:0];
      next_cmdCfg = regs[CFG_ADDR];
      if (shiftNew[7:0] == cmd_power_reset) begin
        for (int i = 0; i < REG_NUM; i++) begin
          next_regs[i] = '0;
        end
      end
    end
  end

  always_ff @(negedge spiClk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt <= '0;
      shiftIn <= '0;
      opcode <= 8'h00;
    end else begin
      bitCnt <= next_bitCnt;
      shiftIn <= next_shiftIn;
      opcode <= next_opcode;
    end
  end

  always_ff @(negedge spiClk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_NUM; i++) begin
        regs[i] <= '0;
      end
      cmdToggle <= 1'b0;
      cmdCode <= 8'h00;
      cmdCfg <= '0;
    end else begin
      regs <= next_regs;
      cmdToggle <= next_cmdToggle;
      cmdCode <= next_cmdCode;
      cmdCfg <= next_cmdCfg;
    end
  end

  // ---------------------------------------------------------------
  // Serial clock domain, rising edge
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] shiftOut, next_shiftOut;
  logic next_serialOut;
  logic next_serialOutEn;
  logic readOp;

  always_comb begin
    readOp = (opcode[7:3] == OP_READ);
    next_shiftOut = {shiftOut[DATA_W-2:0], 1'b0};
    next_serialOut = shiftOut[DATA_W-1];
    next_serialOutEn = readOp && (bitCnt >= CNT_W'(8)) && (bitCnt < CNT_W'(8 + DATA_W));
    if (readOp && bitCnt == CNT_W'(8)) begin
      next_serialOut = regs[opcode[2:0]][DATA_W-1];
      next_shiftOut = {regs[opcode[2:0]][DATA_W-2:0], 1'b0};
    end
    if (!next_serialOutEn) begin
      next_serialOut = 1'b0;
    end
  end

  always_ff @(posedge spiClk or posedge frameRst) begin
    if (frameRst) begin
      shiftOut <= '0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else begin
      shiftOut <= next_shiftOut;
      serialOut <= next_serialOut;
      serialOutEn <= next_serialOutEn;
    end
  end

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  logic [PIN_NUM-1:0] pinRaw, pinMeta, pinSync, pinLast, rise;

  assign pinRaw = {cmdToggle, fast_reference_clock, slow_clock_in, discharge_sense_in, fireIn,
                   stop_b_enable, stop_b_in, stop_a_enable, stop_a_in, startEnable, startIn, reset_in_n};
  assign rise = pinSync & ~pinLast;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinLast <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  // ---------------------------------------------------------------
  // Control sequencer
  // ---------------------------------------------------------------
  tscp_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [4:0] fireLeft, next_fireLeft;
  logic [4:0] halves;
  logic [1:0] portIdx, next_portIdx;
  logic [2:0] seen, next_seen;
  logic [3:0] sensePort, next_sensePort;
  logic [7:0] hitBlock, next_hitBlock;
  logic [7:0] fastCnt, next_fastCnt;
  logic next_pulse_out_a, next_pulse_out_b, next_charge_load_out, next_slow_clock_out;
  logic next_irq_out_n, next_hitStart, next_hitStopA, next_hitStopB;
  logic [15:0] next_resultData;
  logic [2:0] next_resultTag;
  logic next_resultValid, next_convCalStart, next_fastClockOk;
  logic cmdEvent;
  logic hitOk;

  always_comb begin
    cmdEvent = pinSync[PIN_CMD] ^ pinLast[PIN_CMD];
    hitOk = (hitBlock == 8'h00);
    halves = {cmdCfg[FIRE_CNT_LSB +: FIRE_CNT_W], 1'b0};
    next_state = state;
    next_cnt = cnt + 16'h0001;
    next_fireLeft = fireLeft;
    next_portIdx = portIdx;
    next_seen = seen;
    next_sensePort = sensePort;
    next_pulse_out_a = pulse_out_a;
    next_pulse_out_b = pulse_out_b;
    next_charge_load_out = charge_load_out;
    next_irq_out_n = irq_out_n;
    next_resultData = resultData;
    next_resultTag = resultTag;
    next_resultValid = 1'b0;
    next_convCalStart = 1'b0;
    next_fastCnt = (fastCnt == 8'hFF) ? fastCnt : fastCnt + 8'h01;
    next_fastClockOk = (fastCnt == 8'hFF) ? 1'b0 : fastClockOk;
    next_slow_clock_out = pinSync[PIN_SLOW];
    next_hitBlock = (hitBlock == 8'h00) ? hitBlock : hitBlock - 8'h01;
    next_hitStart = rise[PIN_START] && pinSync[PIN_START_EN] && hitOk;
    next_hitStopA = rise[PIN_STOPA] && pinSync[PIN_STOPA_EN] && hitOk;
    next_hitStopB = rise[PIN_STOPB] && pinSync[PIN_STOPB_EN] && hitOk;
    if (rise[PIN_FAST]) begin
      next_fastCnt = 8'h00;
      next_fastClockOk = (fastCnt + 8'h01 >= FAST_MIN_CYC) && (fastCnt <= FAST_MAX_CYC);
    end
    case (state)
      ST_IDLE: begin
        next_cnt = 16'h0000;
      end
      ST_FIRE: begin
        if (cnt == FIRE_HALF_CYC - 16'h0001) begin
          next_cnt = 16'h0000;
          next_fireLeft = fireLeft - 5'h01;
          next_pulse_out_a = (fireLeft != 5'h01) && !pulse_out_a;
          next_pulse_out_b = (fireLeft != 5'h01) && !pulse_out_b;
          if (fireLeft == 5'h01) begin
            next_state = ST_MEAS;
          end
        end
      end
      ST_MEAS: begin
        next_seen = seen | {hitStopB, hitStopA, hitStart};
        if (&seen || cnt == 16'(MEAS_TIMEOUT)) begin
          next_resultData = cnt;
          next_resultTag = TAG_MEAS;
          next_resultValid = 1'b1;
          next_irq_out_n = 1'b0;
          next_state = ST_IDLE;
        end else if (rise[PIN_FIRE] && halves != 5'h00) begin
          next_fireLeft = halves;
          next_cnt = 16'h0000;
          next_pulse_out_a = 1'b1;
          next_pulse_out_b = 1'b0;
          next_state = ST_FIRE;
        end
      end
      ST_LOAD: begin
        next_charge_load_out = 1'b1;
        if (cnt == LOAD_CYC - 16'h0001) begin
          next_charge_load_out = 1'b0;
          next_sensePort = 4'h1 << portIdx;
          next_cnt = 16'h0000;
          next_state = ST_DISCH;
        end
      end
      ST_DISCH: begin
        if (!pinSync[PIN_SENSE] || cnt == 16'(TEMP_TIMEOUT)) begin
          next_sensePort = 4'h0;
          next_resultData = cnt;
          next_resultTag = {1'b0, portIdx};
          next_resultValid = 1'b1;
          next_portIdx = portIdx + 2'h1;
          next_cnt = 16'h0000;
          next_state = ST_LOAD;
          next_charge_load_out = 1'b1;
          if (portIdx == 2'h3) begin
            next_irq_out_n = 1'b0;
            next_charge_load_out = 1'b0;
            next_state = ST_IDLE;
          end
        end
      end
      ST_CALWAIT: begin
        next_cnt = 16'h0000;
        if (rise[PIN_SLOW]) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        next_cnt = rise[PIN_FAST] ? cnt + 16'h0001 : cnt;
        if (rise[PIN_SLOW]) begin
          next_resultData = cnt;
          next_resultTag = TAG_CAL;
          next_resultValid = 1'b1;
          next_irq_out_n = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (cmdEvent) begin
      next_irq_out_n = 1'b1;
      next_cnt = 16'h0000;
      next_seen = 3'h0;
      next_portIdx = 2'h0;
      next_sensePort = 4'h0;
      next_charge_load_out = 1'b0;
      next_pulse_out_a = 1'b0;
      next_pulse_out_b = 1'b0;
      next_state = ST_IDLE;
      case (cmdCode)
        cmd_start_cycle: begin
          next_fireLeft = halves;
          next_pulse_out_a = (halves != 5'h00);
          next_state = (halves != 5'h00) ? ST_FIRE : ST_MEAS;
        end
        cmd_start_temp: begin
          next_state = ST_LOAD;
          next_charge_load_out = 1'b1;
        end
        cmd_calib_resonator: begin
          next_state = ST_CALWAIT;
        end
        cmd_calib_converter: begin
          next_convCalStart = 1'b1;
          next_irq_out_n = 1'b0;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    if (!pinSync[PIN_RESET]) begin
      next_hitBlock = HIT_DELAY_CYC;
      next_state = ST_IDLE;
      next_irq_out_n = 1'b1;
      next_sensePort = 4'h0;
      next_charge_load_out = 1'b0;
      next_pulse_out_a = 1'b0;
      next_pulse_out_b = 1'b0;
      next_convCalStart = 1'b0;
      next_resultValid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      fireLeft <= 5'h00;
      portIdx <= 2'h0;
      seen <= 3'h0;
      sensePort <= 4'h0;
      hitBlock <= HIT_DELAY_CYC;
      fastCnt <= 8'h00;
      pulse_out_a <= 1'b0;
      pulse_out_b <= 1'b0;
      charge_load_out <= 1'b0;
      slow_clock_out <= 1'b0;
      irq_out_n <= 1'b1;
      hitStart <= 1'b0;
      hitStopA <= 1'b0;
      hitStopB <= 1'b0;
      resultData <= 16'h0000;
      resultTag <= 3'h0;
      resultValid <= 1'b0;
      convCalStart <= 1'b0;
      fastClockOk <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      fireLeft <= next_fireLeft;
      portIdx <= next_portIdx;
      seen <= next_seen;
      sensePort <= next_sensePort;
      hitBlock <= next_hitBlock;
      fastCnt <= next_fastCnt;
      pulse_out_a <= next_pulse_out_a;
      pulse_out_b <= next_pulse_out_b;
      charge_load_out <= next_charge_load_out;
      slow_clock_out <= next_slow_clock_out;
      irq_out_n <= next_irq_out_n;
      hitStart <= next_hitStart;
      hitStopA <= next_hitStopA;
      hitStopB <= next_hitStopB;
      resultData <= next_resultData;
      resultTag <= next_resultTag;
      resultValid <= next_resultValid;
      convCalStart <= next_convCalStart;
      fastClockOk <= next_fastClockOk;
    end
  end

  assign sensor_port_a = sensePort[0];
  assign sensor_port_b = sensePort[1];
  assign sensor_port_c = sensePort[2];
  assign sensor_port_d = sensePort[3];

endmodule : tscp_serial_port

// ### verif/tscp_serial_port_checker.sv
// Purpose: Port-level assertions for the serial command port.
// Assumes: Default data width; enables held long before hits.
// Notes: Bound to every instance of the port.
`timescale 1ns/1ns
module tscp_serial_port_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic slave_select_n,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic reset_in_n,
  input wire logic startEnable,
  input wire logic stop_a_enable,
  input wire logic stop_b_enable,
  input wire logic slow_clock_in,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  input wire logic slow_clock_out,
  input wire logic hitStart,
  input wire logic hitStopA,
  input wire logic hitStopB
);
  logic [5:0] sinceRst;
  logic [5:0] next_sinceRst;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Cycles since pin reset release
  // ---------------------------------------------------------------
  always_comb begin
    next_sinceRst = sinceRst;
    if (!reset_in_n) next_sinceRst = 6'h00;
    else if (sinceRst != 6'h3F) next_sinceRst = sinceRst + 6'h01;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sinceRst <= 6'h00;
    else sinceRst <= next_sinceRst;
  end

  sequence s_enHeld;
    serialOutEn [*8];
  endsequence
  property p_readLen;
    @(posedge spiClk) disable iff (rst || slave_select_n) $rose(serialOutEn) |-> s_enHeld;
  endproperty
  a_readLen: assert property (p_readLen) else $error("read data cut short");
  property p_outEnIdle;
    slave_select_n ##1 slave_select_n |-> !serialOutEn;
  endproperty
  a_outEnIdle: assert property (p_outEnIdle) else $error("output enabled while deselected");
  property p_outZero;
    !serialOutEn |-> !serialOut;
  endproperty
  a_outZero: assert property (p_outZero) else $error("output driven while released");
  property p_outChange;
    !slave_select_n && $changed(serialOut) |-> $rose(spiClk);
  endproperty
  a_outChange: assert property (p_outChange) else $error("output changed off rising edge");
  property p_hitGap;
    hitStart || hitStopA || hitStopB |-> sinceRst >= 6'h32;
  endproperty
  a_hitGap: assert property (p_hitGap) else $error("hit too soon after reset");
  property p_stopA;
    (!stop_a_enable) [*6] |-> !hitStopA;
  endproperty
  a_stopA: assert property (p_stopA) else $error("stop A taken while disabled");
  property p_stopB;
    (!stop_b_enable) [*6] |-> !hitStopB;
  endproperty
  a_stopB: assert property (p_stopB) else $error("stop B taken while disabled");
  property p_start;
    (!startEnable) [*6] |-> !hitStart;
  endproperty
  a_start: assert property (p_start) else $error("start taken while disabled");
  property p_pulse;
    !(pulse_out_a && pulse_out_b);
  endproperty
  a_pulse: assert property (p_pulse) else $error("both fire outputs high");
  property p_slowCopy;
    slow_clock_out == $past(slow_clock_in, 3);
  endproperty
  a_slowCopy: assert property (p_slowCopy) else $error("slow clock copy wrong");
endmodule : tscp_serial_port_checker

bind tscp_serial_port tscp_serial_port_checker tscp_serial_port_checker_i (.sys_clk, .rst, .spiClk,
  .slave_select_n, .serialOut, .serialOutEn, .reset_in_n, .startEnable, .stop_a_enable, .stop_b_enable,
  .slow_clock_in, .pulse_out_a, .pulse_out_b, .slow_clock_out, .hitStart, .hitStopA, .hitStopB);

// ### verif/tscp_host_model.sv
// Purpose: Host master on the serial link.
// Assumes: Called at a falling system clock edge.
// Notes: Clock idles low and stands still between frames; edges offset from the system clock.
`timescale 1ns/1ns
module tscp_host_model (
  output logic spiClk,
  output logic slave_select_n,
  output logic serialIn,
  input wire logic serialOut
);
  initial begin
    spiClk = 1'b0;
    slave_select_n = 1'b1;
    serialIn = 1'b1;
  end

  // ---------------------------------------------------------------
  // One frame, MSB first, 64 ns clock
  // ---------------------------------------------------------------
  task automatic frame(input logic [31:0] tx, input int bits, output logic [23:0] rx);
    rx = 24'h000000;
    #3;
    slave_select_n = 1'b0;
    for (int i = 31; i > 31 - bits; i--) begin
      #32;
      spiClk = 1'b1;
      serialIn = tx[i];
      #32;
      spiClk = 1'b0;
      rx = {rx[22:0], serialOut};
    end
    #32;
    slave_select_n = 1'b1;
    serialIn = ~serialIn;
    #32;
  endtask : frame
endmodule : tscp_host_model

// ### verif/tscp_serial_port_bench.sv
// Purpose: Self-checking bench of the serial command port.
// Assumes: Timeouts shortened to 200 cycles.
// Notes: Sense input held low; fire input pulsed once in a measurement.
`timescale 1ns/1ns
module tscp_serial_port_bench;
  import tscp_pkg::*;
  logic sys_clk, rst, spiClk, slave_select_n, serialIn, serialOut, serialOutEn, reset_in_n;
  logic fireIn, discharge_sense_in, slow_clock_in, fast_reference_clock, pulse_out_a, pulse_out_b;
  logic sensor_port_a, sensor_port_b, sensor_port_c, sensor_port_d, charge_load_out, slow_clock_out;
  logic irq_out_n, resultValid, convCalStart, fastClockOk;
  logic [2:0] hitIn, hitEn, hitOut, resultTag;
  logic [2:0] lastTag = 3'h7;
  logic [15:0] resultData;
  int fail_count = 0;
  int check_count = 0;
  int nHit[3];
  int nCal, nFireA, nFireB, nValid, nLoad;
  int nPort;
  logic [3:0] portSeen = 4'h0;

  tscp_serial_port #(.MEAS_TIMEOUT(200), .TEMP_TIMEOUT(200)) tscp_serial_port_i (.sys_clk, .rst, .spiClk,
    .slave_select_n, .serialIn, .serialOut, .serialOutEn, .reset_in_n, .startIn(hitIn[0]),
    .startEnable(hitEn[0]), .stop_a_in(hitIn[1]), .stop_a_enable(hitEn[1]), .stop_b_in(hitIn[2]),
    .stop_b_enable(hitEn[2]), .fireIn, .discharge_sense_in, .slow_clock_in, .fast_reference_clock,
    .pulse_out_a, .pulse_out_b, .sensor_port_a, .sensor_port_b, .sensor_port_c, .sensor_port_d,
    .charge_load_out, .slow_clock_out, .irq_out_n, .hitStart(hitOut[0]), .hitStopA(hitOut[1]),
    .hitStopB(hitOut[2]), .resultData, .resultTag, .resultValid, .convCalStart, .fastClockOk);
  tscp_host_model tscp_host_model_i (.spiClk, .slave_select_n, .serialIn, .serialOut);

  // ---------------------------------------------------------------
  // Clocks, counters, checking
  // ---------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  always begin
    repeat (100) @(negedge sys_clk);
    slow_clock_in <= ~slow_clock_in;
  end
  always begin
    repeat (31) @(negedge sys_clk);
    fast_reference_clock <= ~fast_reference_clock;
  end
  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) nHit[i] += int'(hitOut[i] === 1'b1);
    nCal += int'(convCalStart === 1'b1);
    nFireA += int'(pulse_out_a === 1'b1);
    nFireB += int'(pulse_out_b === 1'b1);
    nValid += int'(resultValid === 1'b1);
    nLoad += int'(charge_load_out === 1'b1);
    nPort += int'(sensor_port_a === 1'b1) + int'(sensor_port_b === 1'b1) + int'(sensor_port_c === 1'b1)
      + int'(sensor_port_d === 1'b1);
    portSeen |= {sensor_port_d, sensor_port_c, sensor_port_b, sensor_port_a};
    if (resultValid === 1'b1) lastTag = resultTag;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED %0t %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask : check
  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    logic [23:0] q;
    @(negedge sys_clk);
    tscp_host_model_i.frame({OP_WRITE, a, d}, 32, q);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [23:0] q);
    @(negedge sys_clk);
    tscp_host_model_i.frame({OP_READ, a, 24'h000000}, 32, q);
  endtask : rd
  task automatic cmd(input logic [7:0] op, input int wait_cyc);
    logic [23:0] q;
    @(negedge sys_clk);
    tscp_host_model_i.frame({op, 24'h000000}, 8, q);
    repeat (wait_cyc) @(negedge sys_clk);
  endtask : cmd

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [23:0] q;
    for (int a = 7; a >= 0; a--) wr(3'(a), 24'hC3A5F1 ^ 24'(a));
    for (int a = 0; a < REG_NUM; a++) begin
      rd(3'(a), q);
      check(32'(q), 32'(24'hC3A5F1 ^ 24'(a)), "register readback");
    end
  endtask : t_regs
  task automatic t_cmds;
    logic [23:0] q;
    cmd(cmd_calib_converter, 20);
    check(32'(nCal), 32'h1, "converter calibration");
    check(32'(irq_out_n), 32'h0, "irq after calibration");
    cmd(cmd_init, 20);
    check(32'(irq_out_n), 32'h1, "irq after init");
    nValid = 0;
    cmd(cmd_start_cycle, 100);
    fireIn = 1'b1;
    repeat (4) @(negedge sys_clk);
    fireIn = 1'b0;
    repeat (400) @(negedge sys_clk);
    check(32'(nFireA), 32'h20, "fire a cycles");
    check(32'(nFireB), 32'h20, "fire b cycles");
    check(32'({nValid[3:0], lastTag, irq_out_n}), {24'h0, 4'h1, TAG_MEAS, 1'b0}, "measure end");
    check(32'(resultData), 32'hC8, "measure timeout count");
    nValid = 0;
    cmd(cmd_start_temp, 600);
    check(32'(nLoad), 32'h100, "load cycles");
    check(32'({nPort[3:0], portSeen}), 32'h4F, "sensor ports");
    check(32'({nValid[3:0], lastTag, irq_out_n}), {24'h0, 4'h4, 3'h3, 1'b0}, "temperature end");
    cmd(cmd_calib_resonator, 600);
    check(32'(lastTag), 32'(TAG_CAL), "resonator calibration");
    check(32'(fastClockOk), 32'h1, "fast clock range");
    cmd(cmd_power_reset, 20);
    rd(3'h5, q);
    check(32'({q, irq_out_n}), 32'h1, "power reset");
  endtask : t_cmds
  task automatic hit(input int ch, input logic en, input int want);
    hitEn[ch] = en;
    nHit[ch] = 0;
    repeat (8) @(negedge sys_clk);
    hitIn[ch] = 1'b1;
    repeat (4) @(negedge sys_clk);
    hitIn[ch] = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(32'(nHit[ch]), 32'(want), "hit count");
    hitEn[ch] = 1'b1;
  endtask : hit
  task automatic t_hits;
    @(negedge sys_clk);
    reset_in_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    reset_in_n = 1'b1;
    hit(0, 1'b1, 0);
    repeat (60) @(negedge sys_clk);
    for (int ch = 0; ch < 3; ch++) begin
      hit(ch, 1'b0, 0);
      hit(ch, 1'b1, 1);
    end
  endtask : t_hits

  initial begin
    {sys_clk, rst, reset_in_n, fireIn, discharge_sense_in} = 5'b01100;
    {slow_clock_in, fast_reference_clock, hitIn, hitEn} = 8'h07;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (60) @(negedge sys_clk);
    t_regs();
    t_cmds();
    t_hits();
    give_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule : tscp_serial_port_bench
